// [rbseq_top.sv]
// Reset generator and brown-out sequencer with an AHB-Lite register port.
// Assumes comparator and pin inputs are asynchronous; CPU, watchdog and wake
// inputs come from logic on mclk.
`timescale 1ns/100ps
// Summary of operation
// - Hold power-on reset until supplies good
// - Power-on reset initialises every register except status
// - Hardware reset from pin, watchdog, POR, debugger
// - Software reset from bit, hardware reset, core
// - Wake from sleep reboots when enabled
// - Hardware reset restarts cold boot sequence
// - Software request ORs register bit and core
// - Status registers cleared only by power-up reset
// - Scratch and soft-reboot bit cleared by software reset; control registers by hardware reset
// - Enabled non-battery rail below threshold forces power-on reset
// - Machine steps on 25% pulses from 1 MHz
// - Thresholds from register, per-rail and global enables
// - Idle, five sensing states, done, back idle
// - Sensing states before battery reset on low enabled rail
// - Battery state raises converter interrupt, never resets
// - Done state stops RC oscillator, returns idle
// - Extended sleep start needs nonzero sleep timer
// - External reset pin is active high
module rbseq_top
  import rbseq_pkg::*;
(
  input  wire logic               mclk,                 // System clock, 200 MHz.
  input  wire logic               sys_rst,              // Power-up reset, active high.
  input  wire logic               hsel,                 // AHB slave select.
  input  wire logic [31:0]        haddr,                // AHB address.
  input  wire logic [1:0]         htrans,               // AHB transfer type.
  input  wire logic               hwrite,               // AHB write flag.
  input  wire logic [2:0]         hsize,                // AHB transfer size.
  input  wire logic [31:0]        hwdata,               // AHB write data.
  input  wire logic               hready,               // AHB bus ready.
  output logic                    hreadyout,            // Slave ready, high outside reset.
  output logic                    hresp,                // Slave response, always OKAY.
  output logic [31:0]             hrdata,               // AHB read data.
  input  wire logic               reset_pin,            // External reset, active high.
  input  wire logic               wdog_expire,          // Watchdog expiry pulse.
  input  wire logic               core_sysreset_req,    // Core reset request pulse.
  input  wire logic               wake_evt,             // Wakeup from sleep pulse.
  input  wire logic               wake_from_ext,        // Wakeup was from extended sleep.
  input  wire logic               core_ok,              // Core supply above minimum.
  input  wire logic [N_RAILS-1:0] rail_low,             // Rail below threshold flags.
  input  wire logic               rc_osc_fast,          // 16 MHz RC oscillator.
  output rbseq_rst_t              rst_out,              // Reset domain outputs.
  output logic                    cold_start_q,         // Boot ROM restart pulse.
  output logic [THR_W-1:0]        bo_thresh_q,          // Comparator threshold setting.
  output logic                    rc_osc_off_q,         // Request to stop RC oscillator.
  output logic                    converter_low_batt_irq, // Battery low interrupt level.
  output logic                    brownout_fsm_clock    // 1 MHz brown-out clock.
);
  logic [N_RAILS-1:0] rail_low_s;
  logic               pin_s;
  logic               core_ok_s;
  logic               step_q;
  logic               step_rise;

  rbseq_sync #(.W(N_RAILS + 2)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d       ({rail_low, reset_pin, core_ok}),
    .q       ({rail_low_s, pin_s, core_ok_s})
  );

  rbseq_bodclk u_bodclk (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .rc_osc_fast (rc_osc_fast),
    .fsm_clk_q   (brownout_fsm_clock),
    .step_q      (step_q),
    .step_rise   (step_rise)
  );

  // Reset domains and their state.
  logic               por_q;
  logic               hw_q;
  logic               sw_q;
  logic               soft_req_q;
  logic               wake_en_q;
  logic               dbg_req_q;
  logic [N_RAILS:0]   bo_en_q;
  logic [TMR_W-1:0]   slp_tmr_q;
  logic [31:0]        scratch_q;
  logic [N_RAILS-1:0] bo_fail_q;
  logic               bo_pass_q;
  logic               pass_ok_q;
  logic               irq_q;
  rbseq_bo_st_t       st_q;
  rbseq_bo_st_t       st_d;

  assign rst_out = '{por: por_q, hw: hw_q, sw: sw_q};
  assign converter_low_batt_irq = irq_q;

  // Bus decode.
  logic       dp_wr_q;
  logic [4:0] dp_addr_q;
  wire        ap_take = hsel & hready & htrans[1];
  wire [4:0]  ap_addr = haddr[4:0];
  wire        wr_sys  = dp_wr_q & (dp_addr_q == OFF_SYS_CTRL);
  wire        wr_pmu  = dp_wr_q & (dp_addr_q == OFF_PMU_CTRL);
  wire        wr_dbg  = dp_wr_q & (dp_addr_q == OFF_DBG_RST);
  wire        wr_thr  = dp_wr_q & (dp_addr_q == OFF_BO_THR);
  wire        wr_en   = dp_wr_q & (dp_addr_q == OFF_BO_EN);
  wire        wr_tmr  = dp_wr_q & (dp_addr_q == OFF_SLP_TMR);
  wire        wr_scr  = dp_wr_q & (dp_addr_q == OFF_SCRATCH);

  wire [31:0] status_word = {16'h0000, 3'b000, bo_fail_q, 1'b0, rc_osc_off_q,
                             irq_q, bo_pass_q, st_q};
  logic [31:0] rd_word;
  always_comb begin
    unique case (ap_addr)
      OFF_SYS_CTRL: rd_word = 32'(soft_req_q);
      OFF_PMU_CTRL: rd_word = 32'(wake_en_q);
      OFF_DBG_RST:  rd_word = 32'(dbg_req_q);
      OFF_BO_THR:   rd_word = 32'(bo_thresh_q);
      OFF_BO_EN:    rd_word = 32'(bo_en_q);
      OFF_SLP_TMR:  rd_word = 32'(slp_tmr_q);
      OFF_STATUS:   rd_word = status_word;
      OFF_SCRATCH:  rd_word = scratch_q;
      default:      rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 5'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      dp_wr_q   <= ap_take & hwrite;
      if (ap_take) begin
        dp_addr_q <= ap_addr;
        hrdata    <= rd_word;
      end
    end
  end

  // Brown-out checks; each sensing state looks at one rail.
  logic [N_RAILS-1:0] sense_sel;
  always_comb begin
    sense_sel = '0;
    unique case (st_q)
      bo_state_core:    sense_sel[R_CORE]   = 1'b1;
      bo_state_1v8:     sense_sel[R_1V8]    = 1'b1;
      bo_state_1v8_pad: sense_sel[R_1V8PAD] = 1'b1;
      bo_state_3v3:     sense_sel[R_3V3]    = 1'b1;
      bo_state_battery: sense_sel[R_BATT]   = 1'b1;
      default:          sense_sel = '0;
    endcase
  end

  wire [N_RAILS-1:0] rail_en  = bo_en_q[BO_RAIL_LSB +: N_RAILS];
  wire [N_RAILS-1:0] rail_hit = sense_sel & rail_low_s & rail_en;
  wire               bo_fault = bo_en_q[BIT_BO_REBOOT] & step_rise
                              & (|rail_hit[R_3V3:R_CORE]);
  wire               batt_low = step_rise & rail_hit[R_BATT];
  wire               tmr_ok   = ~wake_from_ext | (slp_tmr_q != '0);
  wire               bo_start = (st_q == bo_state_idle)
                              & ((wake_evt & tmr_ok) | ~bo_pass_q);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      bo_state_idle:    if (bo_start) st_d = bo_state_core;
      bo_state_core:    if (step_rise) st_d = bo_state_1v8;
      bo_state_1v8:     if (step_rise) st_d = bo_state_1v8_pad;
      bo_state_1v8_pad: if (step_rise) st_d = bo_state_3v3;
      bo_state_3v3:     if (step_rise) st_d = bo_state_battery;
      bo_state_battery: if (step_rise) st_d = bo_state_done;
      bo_state_done:    if (step_rise) st_d = bo_state_idle;
      default:          st_d = bo_state_idle;
    endcase
  end

  // The machine is the detector itself, so only power-up resets it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q         <= bo_state_idle;
      bo_pass_q    <= 1'b0;
      pass_ok_q    <= 1'b0;
      rc_osc_off_q <= 1'b0;
      irq_q        <= 1'b0;
      bo_fail_q    <= '0;
    end else begin
      st_q <= st_d;
      if (bo_fault) begin
        bo_pass_q <= 1'b0;
        bo_fail_q <= bo_fail_q | rail_hit;
      end else if (st_q == bo_state_done && step_rise) begin
        bo_pass_q <= pass_ok_q;
      end
      // A pass that saw a fault must not release power-on reset at its end.
      if (bo_start) begin
        pass_ok_q <= 1'b1;
      end else if (bo_fault) begin
        pass_ok_q <= 1'b0;
      end
      if (bo_start) begin
        rc_osc_off_q <= 1'b0;
      end else if (st_q == bo_state_done && step_rise) begin
        rc_osc_off_q <= 1'b1;
      end
      if (batt_low) begin
        irq_q <= 1'b1;
      end else if (st_q == bo_state_core && step_rise) begin
        irq_q <= 1'b0;
      end
    end
  end

  // Reset chain: power-on feeds hardware, hardware feeds software.
  wire por_d = sys_rst | ~core_ok_s | ~bo_pass_q | bo_fault;
  wire wake_reboot = wake_evt & wake_en_q;
  wire hw_d  = por_q | pin_s | wdog_expire | dbg_req_q | wake_reboot;
  wire sw_d  = hw_q | soft_req_q | core_sysreset_req;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      por_q        <= 1'b1;
      hw_q         <= 1'b1;
      sw_q         <= 1'b1;
      cold_start_q <= 1'b0;
    end else begin
      por_q        <= por_d;
      hw_q         <= hw_d;
      sw_q         <= sw_d;
      cold_start_q <= hw_q & ~hw_d;
    end
  end

  // Control registers cleared by the hardware reset only. The request bits
  // drop once their reset has been taken, so a reset cannot latch itself.
  always_ff @(posedge mclk) begin
    if (hw_q) begin
      wake_en_q   <= 1'b0;
      dbg_req_q   <= 1'b0;
      bo_thresh_q <= BO_THR_RST;
      bo_en_q     <= BO_EN_RST;
      slp_tmr_q   <= SLP_TMR_RST;
    end else begin
      if (wr_pmu) wake_en_q <= hwdata[BIT_WAKE_REBOOT];
      if (wr_dbg) dbg_req_q <= hwdata[BIT_DBG_REQ];
      if (wr_thr) bo_thresh_q <= hwdata[THR_W-1:0];
      if (wr_en) bo_en_q <= hwdata[N_RAILS:0];
      if (wr_tmr) slp_tmr_q <= hwdata[TMR_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (hw_q || sw_q) begin
      soft_req_q <= 1'b0;
    end else if (wr_sys) begin
      soft_req_q <= hwdata[BIT_SOFT_REBOOT];
    end
  end

  always_ff @(posedge mclk) begin
    if (sw_q) begin
      scratch_q <= SCRATCH_RST;
    end else if (wr_scr) begin
      scratch_q <= hwdata;
    end
  end

  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence fault_seen;
    bo_fault;
  endsequence
  sequence por_follows;
    !bo_pass_q && por_q ##1 hw_q ##1 sw_q;
  endsequence

  core_low_por_a: assert property (!core_ok_s |=> por_q)
    else $error("POR released while core supply low");
  por_chain_a: assert property (fault_seen |=> por_follows)
    else $error("Brown-out fault did not propagate through resets");
  por_to_hw_a: assert property (por_q |=> hw_q)
    else $error("POR did not drive hardware reset");
  pin_hw_a: assert property (pin_s |=> hw_q)
    else $error("Reset pin high without hardware reset");
  hw_to_sw_a: assert property (hw_q |=> sw_q)
    else $error("Hardware reset did not drive software reset");
  core_req_a: assert property (core_sysreset_req |=> sw_q)
    else $error("Core reset request ignored");
  wake_boot_a: assert property (wake_evt && wake_en_q |=> hw_q ##1 sw_q)
    else $error("Wake reboot did not reset");
  cold_pulse_a: assert property ($fell(hw_q) |-> cold_start_q ##1 !cold_start_q)
    else $error("Cold start pulse wrong");
  batt_safe_a: assert property (st_q == bo_state_battery |-> !bo_fault)
    else $error("Battery state raised a reset");
  batt_irq_a: assert property (batt_low |=> irq_q)
    else $error("Battery low without interrupt");
  done_idle_a: assert property (st_q == bo_state_done && step_rise
                                |=> st_q == bo_state_idle && rc_osc_off_q)
    else $error("Done state did not stop RC and return idle");
  ext_zero_a: assert property (st_q == bo_state_idle && bo_pass_q && wake_evt
                               && wake_from_ext && slp_tmr_q == '0
                               |=> st_q == bo_state_idle)
    else $error("Machine started with zero sleep timer");
  sw_keeps_a: assert property (sw_q && !hw_q |=> $stable(bo_en_q))
    else $error("Software reset touched control register");
  sw_clears_a: assert property (sw_q |=> scratch_q == SCRATCH_RST)
    else $error("Software reset missed scratch register");

  // The step level and the state register must agree with the step pulse.
  step_duty_a: assert property (step_rise |=> step_q)
    else $error("Step level missing after step pulse");
  st_hold_a: assert property (st_q != bo_state_idle && !step_rise |=> $stable(st_q))
    else $error("State moved without a step pulse");
  idle_start_a: assert property (st_q == bo_state_idle && !bo_pass_q
                                 |-> ##[1:2] st_q == bo_state_core)
    else $error("Machine did not restart after a failed pass");
  pass_clean_a: assert property (st_q == bo_state_done && step_rise && !pass_ok_q
                                 |=> !bo_pass_q)
    else $error("Faulted pass reported supplies good");
  rail_fault_a: assert property (step_rise && st_q == bo_state_1v8 && rail_low_s[R_1V8]
                                 && bo_en_q[BIT_BO_REBOOT]
                                 && bo_en_q[BO_RAIL_LSB + R_1V8] |=> por_q)
    else $error("Low rail did not raise power-on reset");
  irq_clear_a: assert property (st_q == bo_state_core && step_rise |=> !irq_q)
    else $error("Converter interrupt not cleared by new pass");
  rc_run_a: assert property (bo_start |=> !rc_osc_off_q)
    else $error("RC oscillator left stopped at pass start");
  soft_clear_a: assert property (sw_q |=> !soft_req_q)
    else $error("Soft reboot bit did not clear");
  dbg_hw_a: assert property (dbg_req_q |=> hw_q)
    else $error("Debugger request without hardware reset");
  wdog_hw_a: assert property (wdog_expire |=> hw_q)
    else $error("Watchdog expiry without hardware reset");
  cold_only_a: assert property (cold_start_q |-> !hw_q)
    else $error("Cold start pulse while hardware reset held");

endmodule : rbseq_top

// [rbseq_pkg.sv]
// Shared constants and types for the reset and brown-out sequencer.
// Assumes a single 200 MHz system clock and an AHB-Lite register port.
package rbseq_pkg;

  // Register byte offsets.
  localparam logic [4:0] OFF_SYS_CTRL = 5'h00;
  localparam logic [4:0] OFF_PMU_CTRL = 5'h04;
  localparam logic [4:0] OFF_DBG_RST  = 5'h08;
  localparam logic [4:0] OFF_BO_THR   = 5'h0C;
  localparam logic [4:0] OFF_BO_EN    = 5'h10;
  localparam logic [4:0] OFF_SLP_TMR  = 5'h14;
  localparam logic [4:0] OFF_STATUS   = 5'h18;
  localparam logic [4:0] OFF_SCRATCH  = 5'h1C;

  // Field positions.
  localparam int BIT_SOFT_REBOOT = 0;
  localparam int BIT_WAKE_REBOOT = 0;
  localparam int BIT_DBG_REQ     = 0;
  localparam int BIT_BO_REBOOT   = 0;
  localparam int BO_RAIL_LSB     = 1;
  localparam int ST_STATE_LSB    = 0;
  localparam int ST_PASS_BIT     = 4;
  localparam int ST_IRQ_BIT      = 5;
  localparam int ST_RCOFF_BIT    = 6;
  localparam int ST_FAIL_LSB     = 8;

  // Sensed rails, in the order the machine visits them.
  localparam int N_RAILS  = 5;
  localparam int R_CORE   = 0;
  localparam int R_1V8    = 1;
  localparam int R_1V8PAD = 2;
  localparam int R_3V3    = 3;
  localparam int R_BATT   = 4;

  // Widths and reset values.
  localparam int THR_W = 16;
  localparam int TMR_W = 16;
  localparam logic [THR_W-1:0]   BO_THR_RST = 16'h0000;
  localparam logic [N_RAILS:0]   BO_EN_RST  = 6'h3F;
  localparam logic [TMR_W-1:0]   SLP_TMR_RST = 16'h0000;
  localparam logic [31:0]        SCRATCH_RST = 32'h00000000;

  // RC oscillator divides by 16 to 1 MHz; steps run at a quarter of that.
  localparam int RC_DIV   = 16;
  localparam int STEP_DIV = 4;

  typedef enum logic [3:0] {
    bo_state_idle, bo_state_core, bo_state_1v8, bo_state_1v8_pad,
    bo_state_3v3, bo_state_battery, bo_state_done
  } rbseq_bo_st_t;

  typedef struct packed {
    logic por;
    logic hw;
    logic sw;
  } rbseq_rst_t;

endpackage : rbseq_pkg

// [rbseq_sync.sv]
// Two-stage synchroniser for levels that arrive from outside mclk.
// Assumes the inputs are slow against the 5 ns clock period.
`timescale 1ns/100ps
module rbseq_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,    // System clock.
  input  wire logic         sys_rst, // Synchronous reset, active high.
  input  wire logic [W-1:0] d,       // Asynchronous input.
  output logic      [W-1:0] q        // Synchronised output.
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : rbseq_sync

// [rbseq_bodclk.sv]
// Derives the 1 MHz brown-out clock and the 25% step pulses from the RC oscillator.
// Assumes the RC clock arrives as a pin far slower than mclk.
`timescale 1ns/100ps
module rbseq_bodclk
  import rbseq_pkg::*;
(
  input  wire logic mclk,        // System clock.
  input  wire logic sys_rst,     // Synchronous reset, active high.
  input  wire logic rc_osc_fast, // 16 MHz RC oscillator, asynchronous.
  output logic      fsm_clk_q,   // 1 MHz brown-out clock level.
  output logic      step_q,      // 250 kHz step level, 25% high.
  output logic      step_rise    // One mclk pulse at each step start.
);
  logic [1:0]                    rc_sync_q;
  logic                          rc_old_q;
  logic [$clog2(RC_DIV)-1:0]     div_q;
  logic [$clog2(STEP_DIV)-1:0]   phase_q;
  wire                           rc_edge = rc_sync_q[1] & ~rc_old_q;
  wire                           tick    = rc_edge & (div_q == $bits(div_q)'(RC_DIV - 1));
  wire                           last_ph = phase_q == $bits(phase_q)'(STEP_DIV - 1);

  assign step_rise = tick & last_ph;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rc_sync_q <= '0;
      rc_old_q  <= 1'b0;
      div_q     <= '0;
      phase_q   <= '0;
      fsm_clk_q <= 1'b0;
      step_q    <= 1'b0;
    end else begin
      rc_sync_q <= {rc_sync_q[0], rc_osc_fast};
      rc_old_q  <= rc_sync_q[1];
      if (rc_edge) begin
        div_q     <= div_q + 1'b1;
        fsm_clk_q <= ~div_q[$bits(div_q)-1];
      end
      if (tick) begin
        phase_q <= phase_q + 1'b1;
        step_q  <= last_ph;
      end
    end
  end
endmodule : rbseq_bodclk

// [rbseq_supply_model.sv]
// Behavioural model of the supply comparators, the reset button and the RC oscillator.
// Assumes the bench commands supply dips and button presses; the oscillator obeys the stop request.
`timescale 1ns/100ps
module rbseq_supply_model
  import rbseq_pkg::*;
(
  input  wire logic             rc_stop,     // Oscillator stop request.
  input  wire logic             pin_press,   // Reset button held.
  input  wire logic [N_RAILS:0] supply_dip,  // Top bit: core below its minimum.
  output logic                  rc_osc_fast, // RC clock near 16 MHz.
  output logic                  reset_pin,   // Pad level, pulled down when idle.
  output logic                  core_ok,     // Core supply good.
  output logic [N_RAILS-1:0]    rail_low     // Rails below threshold.
);
  // A stopped oscillator parks low, so a machine that still needs it will hang and be seen.
  initial rc_osc_fast = 1'b0;
  always #31 rc_osc_fast = rc_stop ? 1'b0 : ~rc_osc_fast;
  assign reset_pin = pin_press;
  assign core_ok   = ~supply_dip[N_RAILS];
  assign rail_low  = supply_dip[N_RAILS-1:0];
endmodule : rbseq_supply_model

// [test_reset_and_brownout_sequencer.sv]
// Self-checking bench for the reset and brown-out sequencer.
// Assumes the supply model drives the analog side; registers are reached over AHB-Lite.
`timescale 1ns/100ps
module test_reset_and_brownout_sequencer
  import rbseq_pkg::*;
;
  logic               mclk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]        haddr, hwdata, hrdata, r;
  logic [1:0]         htrans;
  logic               wdog, core_req, wake_evt, wake_ext, press, rc_fast, pin, core_ok;
  logic               cold, rc_off, irq, fclk;
  logic [N_RAILS-1:0] rail_low;
  logic [N_RAILS:0]   dip;
  logic [THR_W-1:0]   thr;
  rbseq_rst_t         rst;
  logic [31:0]        exp_reg [8];
  logic [31:0]        wmask [8];
  int                 fail_count, check_count, seed, h;
  int                 por_hits = 0;
  int                 rc_edges = 0;
  int                 fclk_mark = 0;
  int                 fclk_per = 0;

  assign hready = hreadyout;

  rbseq_top dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reset_pin(pin),
    .wdog_expire(wdog), .core_sysreset_req(core_req), .wake_evt(wake_evt),
    .wake_from_ext(wake_ext), .core_ok(core_ok), .rail_low(rail_low),
    .rc_osc_fast(rc_fast), .rst_out(rst), .cold_start_q(cold), .bo_thresh_q(thr),
    .rc_osc_off_q(rc_off), .converter_low_batt_irq(irq), .brownout_fsm_clock(fclk));

  rbseq_supply_model model (.rc_stop(rc_off), .pin_press(press), .supply_dip(dip),
    .rc_osc_fast(rc_fast), .reset_pin(pin), .core_ok(core_ok), .rail_low(rail_low));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rst.por && !sys_rst) por_hits <= por_hits + 1;
  end

  // RC edges per brown-out clock period, measured between its rising edges.
  always @(posedge rc_fast) rc_edges <= rc_edges + 1;
  always @(posedge fclk) begin
    fclk_per  <= rc_edges - fclk_mark;
    fclk_mark <= rc_edges;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  function automatic logic pick(input int s);
    case (s)
      0: return rst.por;
      1: return rst.hw;
      2: return rst.sw;
      3: return irq;
      default: return rc_off;
    endcase
  endfunction : pick

  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        chk($sformatf("wait%0d", s), pick(s), v);
        end_sim();
      end
    end while (pick(s) !== v);
  endtask : wait_for

  task automatic rdy_wait;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      chk("hreadyout", hreadyout, 1);
      end_sim();
    end
  endtask : rdy_wait

  // Each call holds both phases until ready is sampled high, takes the read
  // data at that edge, and returns once the written value has settled.
  task automatic bus(input logic w, input int idx, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= 32'(idx) << 2;
    htrans <= 2'h2;
    hwrite <= w;
    rdy_wait();
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait();
    r = hrdata;
    chk("hresp", hresp, 0);
    if (w) exp_reg[idx] = d & wmask[idx];
    @(negedge mclk);
  endtask : bus

  task automatic m_rst(input bit hw);
    if (hw) begin
      for (int i = 0; i < 6; i++) exp_reg[i] = 32'h0;
      exp_reg[4] = 32'h3F;
    end
    exp_reg[7] = 32'h0;
  endtask : m_rst

  task automatic rd_all;
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        bus(1'b0, i, 32'h0);
        chk($sformatf("reg%0d", i), r, exp_reg[i]);
      end
    end
  endtask : rd_all

  task automatic hw_release;
    wait_for(1, 1'b0, 8);
    chk("cold", cold, 1);
    chk("sw", rst.sw, 1);
    @(negedge mclk);
    chk("sw", rst.sw, 0);
    chk("cold", cold, 0);
  endtask : hw_release

  task automatic pulse_wake(input logic ext);
    @(posedge mclk);
    wake_ext <= ext;
    wake_evt <= 1'b1;
    @(posedge mclk);
    wake_evt <= 1'b0;
  endtask : pulse_wake

  initial begin
    seed = 32'h05204069;
    wmask = '{32'h0, 32'h1, 32'h0, 32'hFFFF, 32'h3F, 32'hFFFF, 32'h0, 32'hFFFFFFFF};
    {sys_rst, dip} = {1'b1, 6'h20};
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {wdog, core_req, wake_evt, wake_ext, press} = 5'h00;
    m_rst(1);
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (400) @(posedge mclk);
    @(negedge mclk);
    chk("por", rst.por, 1);
    @(posedge mclk);
    dip <= 6'h00;
    wait_for(0, 1'b0, 12000);
    chk("hw", rst.hw, 1);
    chk("fclk", fclk_per, RC_DIV);
    hw_release();
    rd_all();
    for (int i = 1; i < 8; i++) begin
      if (wmask[i] != 0) bus(1'b1, i, $random(seed));
    end
    rd_all();
    chk("thresh", thr, exp_reg[3][15:0]);
    bus(1'b1, 0, 32'h1);
    wait_for(2, 1'b1, 6);
    chk("hw", rst.hw, 0);
    wait_for(2, 1'b0, 6);
    m_rst(0);
    rd_all();
    @(posedge mclk);
    core_req <= 1'b1;
    @(posedge mclk);
    core_req <= 1'b0;
    wait_for(2, 1'b1, 6);
    chk("hw", rst.hw, 0);
    wait_for(2, 1'b0, 6);
    m_rst(0);
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, 7, $random(seed));
      if (s == 2) bus(1'b1, 2, 32'h1);
      else begin
        @(posedge mclk);
        press <= (s == 0);
        wdog  <= (s == 1);
        repeat (3) @(posedge mclk);
        {press, wdog} <= 2'h0;
      end
      wait_for(1, 1'b1, 8);
      hw_release();
      m_rst(1);
      rd_all();
    end
    bus(1'b1, 1, 32'h1);
    pulse_wake(1'b1);
    wait_for(1, 1'b1, 8);
    hw_release();
    m_rst(1);
    bus(1'b0, 6, 32'h0);
    chk("state", r[3:0], 0);
    chk("rcoff", rc_off, 1);
    bus(1'b1, 3, $random(seed));
    chk("thresh", thr, exp_reg[3][15:0]);
    @(posedge mclk);
    dip <= 6'h02;
    pulse_wake(1'b0);
    wait_for(0, 1'b1, 6000);
    m_rst(1);
    @(posedge mclk);
    dip <= 6'h00;
    wait_for(0, 1'b0, 12000);
    wait_for(2, 1'b0, 8);
    bus(1'b0, 6, 32'h0);
    chk("fail", r[ST_FAIL_LSB+R_1V8], 1);
    chk("pass", r[ST_PASS_BIT], 1);
    chk("thresh", thr, 0);
    rd_all();
    // The 3.3 V rail is masked while it and the battery both read low.
    bus(1'b1, 4, 32'h2F);
    h = por_hits;
    @(posedge mclk);
    dip <= 6'h18;
    pulse_wake(1'b0);
    wait_for(3, 1'b1, 6000);
    wait_for(4, 1'b1, 3000);
    chk("por", por_hits, h);
    bus(1'b0, 6, 32'h0);
    chk("state", r[3:0], 0);
    chk("irq", r[ST_IRQ_BIT], 1);
    end_sim();
  end
endmodule : test_reset_and_brownout_sequencer
